// file: core/dcfmb_top.sv
// Our own choices: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
module dcfmb_top (
    // Clock and reset
    input  wire logic                        mclk,
    input  wire logic                        rst_n,
    // Threshold straps
    input  wire logic                        threshold_sel1,
    input  wire logic                        threshold_sel0,
    // Port A
    input  wire logic                        port_a_clock,
    input  wire dcfmb_pkg::dcfmb_porta_ctl_s port_a_ctl,
    input  wire dcfmb_pkg::dcfmb_word_t      a_data_in,
    output      dcfmb_pkg::dcfmb_word_t      a_data_out,
    output      logic                        a_data_oe,
    output      logic                        queue_full_n,
    output      logic                        near_full_n,
    output      logic                        b_to_a_mail_flag_n,
    // Port B
    input  wire logic                        port_b_clock,
    input  wire dcfmb_pkg::dcfmb_portb_ctl_s port_b_ctl,
    input  wire dcfmb_pkg::dcfmb_word_t      b_data_in,
    output      dcfmb_pkg::dcfmb_word_t      b_data_out,
    output      logic                        b_data_oe,
    output      logic                        queue_empty_n,
    output      logic                        near_empty_n,
    output      logic                        a_to_b_mail_flag_n,
    // Avalon-MM slave
    input  wire logic [3:0]                  avs_address,
    input  wire logic                        avs_read,
    input  wire logic                        avs_write,
    input  wire logic [31:0]                 avs_writedata,
    output      logic [31:0]                 avs_readdata,
    output      logic                        avs_waitrequest
);
    import dcfmb_pkg::*;

    dcfmb_state_s s;
    dcfmb_state_s next_s;
    dcfmb_word_t  mem [DEPTH];

    logic a_edge;
    logic b_edge;
    logic q_write;
    logic ab_mail_wr;
    logic ba_mail_rd;
    logic ba_mail_wr;
    logic ab_mail_rd;
    logic q_read;
    logic b_wide_sel;
    logic fresh;
    logic [1:0] applied_size;

    function automatic logic [4:0] thr_decode(input logic s1, input logic s0);
        case ({s1, s0})
            2'h3:    thr_decode = THR_HH;
            2'h2:    thr_decode = THR_HL;
            2'h1:    thr_decode = THR_LH;
            default: thr_decode = THR_LL;
        endcase
    endfunction

    function automatic logic [1:0] parts_of(input logic [1:0] sz);
        case (sz)
            SZ_WORD: parts_of = 2'h1;
            SZ_BYTE: parts_of = 2'h3;
            default: parts_of = 2'h0;
        endcase
    endfunction

    // Places part idx of w on the lanes the size and endian choose; other lanes keep prev
    function automatic dcfmb_word_t place_part(input dcfmb_word_t w, input dcfmb_word_t prev,
                                               input logic [1:0] sz, input logic [1:0] idx,
                                               input logic be_n);
        dcfmb_word_t r;
        r = prev;
        case (sz)
            SZ_WORD: begin
                if (!be_n) begin
                    r[DATA_W-1 -: HALF_W] = idx[0] ? w[HALF_W-1:0] : w[DATA_W-1 -: HALF_W];
                end else begin
                    r[HALF_W-1:0] = idx[0] ? w[DATA_W-1 -: HALF_W] : w[HALF_W-1:0];
                end
            end
            SZ_BYTE: begin
                if (!be_n) begin
                    r[DATA_W-1 -: BYTE_W] = w[(DATA_W-1 - BYTE_W*idx) -: BYTE_W];
                end else begin
                    r[BYTE_W-1:0] = w[(BYTE_W*idx) +: BYTE_W];
                end
            end
            default: r = w;
        endcase
        return r;
    endfunction

    assign a_edge       = port_a_clock & ~s.a_clk_q;
    assign b_edge       = port_b_clock & ~s.b_clk_q;
    assign b_wide_sel   = port_b_ctl.width_sel1 & port_b_ctl.width_sel0;
    assign applied_size = s.sz_q;
    // A narrow read continues the held word only if nothing is left over in another width
    assign fresh        = (s.parts_left == 2'h0) || (applied_size != s.held_size)
                          || (s.be_q != s.held_be); // RULE_21

    always_comb begin
        q_write    = a_edge && !port_a_ctl.port_a_select_n && port_a_ctl.port_a_dir
                     && port_a_ctl.port_a_go && !port_a_ctl.port_a_mail_sel
                     && s.ful; // RULE_03
        ab_mail_wr = a_edge && !port_a_ctl.port_a_select_n && port_a_ctl.port_a_dir
                     && port_a_ctl.port_a_go && port_a_ctl.port_a_mail_sel
                     && s.mb1_n; // RULE_12
        ba_mail_rd = a_edge && !port_a_ctl.port_a_select_n && !port_a_ctl.port_a_dir
                     && port_a_ctl.port_a_go && port_a_ctl.port_a_mail_sel;
        // Leftover parts may drain while memory is empty; a fresh fetch needs a stored word
        q_read     = b_edge && !port_b_ctl.port_b_select_n && !port_b_ctl.port_b_dir
                     && port_b_ctl.port_b_go && !b_wide_sel
                     && (s.emp || !fresh); // RULE_24 RULE_25
        ab_mail_rd = b_edge && !port_b_ctl.port_b_select_n && !port_b_ctl.port_b_dir
                     && port_b_ctl.port_b_go && b_wide_sel;
        ba_mail_wr = b_edge && !port_b_ctl.port_b_select_n && port_b_ctl.port_b_dir
                     && port_b_ctl.port_b_go && b_wide_sel && s.mb2_n; // RULE_12
    end

    always_comb begin
        dcfmb_ptr_t new_wr;
        dcfmb_ptr_t new_rd;
        new_wr  = s.wr_ptr;
        new_rd  = s.rd_ptr;
        next_s  = s;
        next_s.a_clk_q = port_a_clock;
        next_s.b_clk_q = port_b_clock;

        // Straps are caught on the first clock after release, not under reset
        if (!s.thr_loaded) begin
            next_s.thr        = thr_decode(threshold_sel1, threshold_sel0); // RULE_23
            next_s.thr_loaded = 1'b1;
        end

        // Port A side
        if (q_write) begin
            new_wr = s.wr_ptr + 7'h01;
        end
        if (ab_mail_wr) begin
            next_s.mail_ab = a_data_in; // RULE_10 RULE_16
            next_s.mb1_n   = 1'b0; // RULE_12
        end
        if (ba_mail_rd) begin
            next_s.mb2_n = 1'b1; // RULE_15
        end

        // Port B side
        if (b_edge) begin
            next_s.be_q = port_b_ctl.big_endian_sel_n; // RULE_18
            // Mail accesses keep the previous size selection alive
            if (!b_wide_sel) begin
                next_s.sz_q = {port_b_ctl.width_sel1, port_b_ctl.width_sel0}; // RULE_18
            end
        end
        if (q_read) begin
            if (fresh) begin
                // Memory only moves whole long words; sizing happens after the read
                new_rd           = s.rd_ptr + 7'h01; // RULE_19
                next_s.hold      = mem[s.rd_ptr[5:0]];
                next_s.held_size = applied_size;
                next_s.held_be   = s.be_q;
                next_s.part_idx  = 2'h1;
                next_s.parts_left = parts_of(applied_size);
                next_s.out_reg   = place_part(mem[s.rd_ptr[5:0]], s.out_reg, applied_size,
                                              2'h0, s.be_q); // RULE_17 RULE_20 RULE_22
            end else begin
                next_s.part_idx   = s.part_idx + 2'h1;
                next_s.parts_left = s.parts_left - 2'h1;
                next_s.out_reg    = place_part(s.hold, s.out_reg, s.held_size, s.part_idx,
                                               s.held_be); // RULE_20 RULE_22
            end
        end
        if (ba_mail_wr) begin
            next_s.mail_ba = b_data_in; // RULE_11 RULE_16
            next_s.mb2_n   = 1'b0; // RULE_12
        end
        // A mail write in the same cycle wins, so new mail is never flagged as taken
        if (ab_mail_rd && !ab_mail_wr) begin
            next_s.mb1_n = 1'b1; // RULE_14
        end

        next_s.wr_ptr = new_wr;
        next_s.rd_ptr = new_rd;

        // Pointer views seen by the far side only after the skew has elapsed
        next_s.wr_age = (new_wr != s.wr_ptr) ? 4'h0 : (s.wr_age == 4'hf ? s.wr_age
                                                                          : s.wr_age + 4'h1);
        next_s.rd_age = (new_rd != s.rd_ptr) ? 4'h0 : (s.rd_age == 4'hf ? s.rd_age
                                                                          : s.rd_age + 4'h1);
        if (s.wr_age >= FIRST_SKEW_CYC - 4'h1 && new_wr == s.wr_ptr) begin
            next_s.b_wr_v1 = s.wr_ptr; // RULE_02
        end
        if (s.wr_age >= SECOND_SKEW_CYC - 4'h1 && new_wr == s.wr_ptr) begin
            next_s.b_wr_v2 = s.wr_ptr; // RULE_07
        end
        if (s.rd_age >= FIRST_SKEW_CYC - 4'h1 && new_rd == s.rd_ptr) begin
            next_s.a_rd_v1 = s.rd_ptr; // RULE_05
        end
        if (s.rd_age >= SECOND_SKEW_CYC - 4'h1 && new_rd == s.rd_ptr) begin
            next_s.a_rd_v2 = s.rd_ptr; // RULE_09
        end

        // Two-stage flags: falling is immediate on the local side, rising takes two edges
        if (b_edge) begin
            next_s.emp_s1  = (s.b_wr_v1 != new_rd);
            next_s.emp     = s.emp_s1 && (s.b_wr_v1 != new_rd); // RULE_01
            next_s.nemp_s1 = (7'(s.b_wr_v2 - new_rd) > {2'h0, s.thr});
            next_s.nemp    = s.nemp_s1
                && (7'(s.b_wr_v2 - new_rd) > {2'h0, s.thr}); // RULE_06 RULE_07
        end else if (new_rd != s.rd_ptr) begin
            next_s.emp = s.emp;
        end
        if (a_edge) begin
            next_s.ful_s1  = (7'(new_wr - s.a_rd_v1) != 7'(DEPTH));
            next_s.ful     = s.ful_s1 && (7'(new_wr - s.a_rd_v1) != 7'(DEPTH)); // RULE_03 RULE_04
            next_s.nful_s1 = (7'(new_wr - s.a_rd_v2) < 7'(7'(DEPTH) - {2'h0, s.thr}));
            next_s.nful    = s.nful_s1
                && (7'(new_wr - s.a_rd_v2) < 7'(7'(DEPTH) - {2'h0, s.thr})); // RULE_08 RULE_09
        end

        // Avalon slave: one wait cycle, then the answer stands for one edge
        next_s.ack = (avs_read || avs_write) && !s.ack;
        if (avs_read && !s.ack) begin
            case (avs_address)
                REG_STATUS: next_s.rdata = {11'h000, s.thr, 1'b0, 7'(s.wr_ptr - s.rd_ptr),
                                            2'h0, s.mb2_n, s.mb1_n, s.ful, s.nful,
                                            s.nemp, queue_empty_n};
                REG_CTRL:   next_s.rdata = {27'h0000000, s.thr};
                default:    next_s.rdata = 32'h00000000;
            endcase
        end
        // Software may retune the threshold; the straps only give its value after reset release
        if (avs_write && s.ack && avs_address == REG_CTRL) begin
            next_s.thr = avs_writedata[4:0];
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s       <= '0;
            s.nful    <= 1'b1;
            s.nful_s1 <= 1'b1;
            s.mb1_n <= 1'b1;
            s.mb2_n <= 1'b1;
            s.thr   <= THR_LL;
        end else begin
            s <= next_s;
        end
    end

    // Memory kept outside the state struct: no reset, written on accepted queue writes
    always_ff @(posedge mclk) begin
        if (q_write) begin
            mem[s.wr_ptr[5:0]] <= a_data_in; // RULE_19
        end
    end

    assign queue_empty_n      = s.emp || (s.parts_left != 2'h0); // RULE_24
    assign near_empty_n       = s.nemp;
    assign queue_full_n       = s.ful;
    assign near_full_n        = s.nful;
    assign a_to_b_mail_flag_n = s.mb1_n;
    assign b_to_a_mail_flag_n = s.mb2_n;
    assign a_data_out         = s.mail_ba;
    assign a_data_oe          = !port_a_ctl.port_a_select_n && !port_a_ctl.port_a_dir;
    assign b_data_out         = b_wide_sel ? s.mail_ab : s.out_reg; // RULE_13 RULE_19
    assign b_data_oe          = !port_b_ctl.port_b_select_n && !port_b_ctl.port_b_dir;
    assign avs_readdata       = s.rdata;
    assign avs_waitrequest    = (avs_read || avs_write) && !s.ack;

    // Checks
    property p_full_ignore;
        @(posedge mclk) disable iff (!rst_n)
        (a_edge && !port_a_ctl.port_a_select_n && port_a_ctl.port_a_dir && port_a_ctl.port_a_go
         && !port_a_ctl.port_a_mail_sel && !queue_full_n) |=> $stable(s.wr_ptr);
    endproperty
    a_full_ignore: assert property (p_full_ignore) // RULE_03
        else $error("write accepted while full");

    property p_empty_ignore;
        @(posedge mclk) disable iff (!rst_n)
        (b_edge && !queue_empty_n) |=> ($stable(s.rd_ptr) && $stable(s.out_reg));
    endproperty
    a_empty_ignore: assert property (p_empty_ignore) // RULE_24
        else $error("read accepted while empty");

    property p_empty_two_edges;
        @(posedge mclk) disable iff (!rst_n)
        $rose(s.emp) |-> $past(s.emp_s1);
    endproperty
    a_empty_two_edges: assert property (p_empty_two_edges) // RULE_01
        else $error("empty flag rose early");

    property p_full_two_edges;
        @(posedge mclk) disable iff (!rst_n)
        $rose(queue_full_n) |-> ($past(s.ful_s1) && $past(a_edge));
    endproperty
    a_full_two_edges: assert property (p_full_two_edges) // RULE_04
        else $error("full flag rose early");

    property p_ab_write_flag;
        @(posedge mclk) disable iff (!rst_n)
        ab_mail_wr |=> (!a_to_b_mail_flag_n && s.mail_ab == $past(a_data_in));
    endproperty
    a_ab_write_flag: assert property (p_ab_write_flag) // RULE_10
        else $error("mailbox write lost");

    property p_mail_locked;
        @(posedge mclk) disable iff (!rst_n)
        (!a_to_b_mail_flag_n && !ab_mail_rd) |=> $stable(s.mail_ab);
    endproperty
    a_mail_locked: assert property (p_mail_locked) // RULE_12
        else $error("mailbox changed while full");

    property p_ab_read_flag;
        @(posedge mclk) disable iff (!rst_n)
        (ab_mail_rd && !ab_mail_wr) |=> (a_to_b_mail_flag_n && $stable(s.mail_ab));
    endproperty
    a_ab_read_flag: assert property (p_ab_read_flag) // RULE_14
        else $error("mail read flag wrong");

    property p_ba_read_flag;
        @(posedge mclk) disable iff (!rst_n)
        (ba_mail_rd && !ba_mail_wr) |=> (b_to_a_mail_flag_n && $stable(s.mail_ba));
    endproperty
    a_ba_read_flag: assert property (p_ba_read_flag) // RULE_15
        else $error("mail read flag wrong");

    property p_b_mux;
        @(posedge mclk) disable iff (!rst_n)
        b_data_oe |-> (b_data_out == (b_wide_sel ? s.mail_ab : s.out_reg));
    endproperty
    a_b_mux: assert property (p_b_mux) else $error("port B source wrong"); // RULE_13

    property p_thr_load;
        @(posedge mclk) disable iff (!rst_n)
        $rose(s.thr_loaded)
            |-> (s.thr == thr_decode($past(threshold_sel1), $past(threshold_sel0)));
    endproperty
    a_thr_load: assert property (p_thr_load) else $error("threshold not loaded"); // RULE_23

    property p_ae_level;
        @(posedge mclk) disable iff (!rst_n)
        near_empty_n |-> (7'(s.wr_ptr - s.rd_ptr) > {2'h0, s.thr});
    endproperty
    a_ae_level: assert property (p_ae_level) else $error("near empty high too early"); // RULE_06
endmodule // dcfmb_top

// file: inc/dcfmb_pkg.sv
// What this block does
// RULE_01: Empty flag rises on second port B edge after a write into empty queue.
// RULE_02: A port B edge counts for empty sync only after first skew time.
// RULE_03: Queue writes are ignored while full flag is low.
// RULE_04: Full flag rises on the second port A edge after a freeing read.
// RULE_05: A port A edge counts for full sync only after first skew time.
// RULE_06: Near-empty low at threshold or fewer words, high above it.
// RULE_07: Near-empty rises on second port B edge; first needs second skew time.
// RULE_08: Near-full low at 64 minus threshold or more words, else high.
// RULE_09: Near-full rises on second port A edge; first needs second skew time.
// RULE_10: Port A mail write stores the 36-bit bus into the A-to-B mailbox.
// RULE_11: Port B write with both size selects high stores into B-to-A mailbox.
// RULE_12: Mailbox write drives its flag low; further writes ignored while low.
// RULE_13: Port B drives queue output register, or A-to-B mailbox when both selects high.
// RULE_14: Port B mail read sets the A-to-B mail flag high.
// RULE_15: Port A mail read sets the B-to-A mail flag high.
// RULE_16: Mailbox contents change only on an accepted write.
// RULE_17: Port B reads in long word, word or byte, big or little endian.
// RULE_18: Size and endian selects are registered each edge, applied next edge. The size is not registered on edges with both size selects high.
// RULE_19: Memory holds whole long words; sizing after read, never for mail.
// RULE_20: Narrow reads present first part, hold the rest, output it in order.
// RULE_21: A read with a newly applied width fetches a fresh word, dropping leftovers.
// RULE_22: Unused output lanes keep their last value during narrow reads.
// RULE_23: Threshold loads at reset release from the two select pins: 16,12,8,4.
// RULE_24: Reads ignored while empty; flag falls when last part is read.
// RULE_25: Port B master reads with select low, dir low, go high, a size select low.
package dcfmb_pkg;
    localparam int DATA_W = 36;
    localparam int DEPTH  = 64;
    localparam int PTR_W  = 7;
    localparam int BYTE_W = 9;
    localparam int HALF_W = 18;
    typedef logic [DATA_W-1:0] dcfmb_word_t;
    typedef logic [PTR_W-1:0]  dcfmb_ptr_t;

    localparam int MCLK_MHZ         = 25;
    localparam int FIRST_SKEW_NS    = 5;
    localparam int SECOND_SKEW_NS   = 10;
    localparam int FIRST_SKEW_CYC_I = (FIRST_SKEW_NS * MCLK_MHZ + 999) / 1000;
    localparam int SECOND_SKEW_CYC_I = (SECOND_SKEW_NS * MCLK_MHZ + 999) / 1000;
    localparam logic [3:0] FIRST_SKEW_CYC  = 4'(FIRST_SKEW_CYC_I < 1 ? 1 : FIRST_SKEW_CYC_I);
    localparam logic [3:0] SECOND_SKEW_CYC = 4'(SECOND_SKEW_CYC_I < 1 ? 1 : SECOND_SKEW_CYC_I);

    localparam logic [4:0] THR_HH = 5'h10;
    localparam logic [4:0] THR_HL = 5'h0c;
    localparam logic [4:0] THR_LH = 5'h08;
    localparam logic [4:0] THR_LL = 5'h04;

    // Width select codes {width_sel1, width_sel0}
    localparam logic [1:0] SZ_LONG = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;
    localparam logic [1:0] SZ_BYTE = 2'h2;
    localparam logic [1:0] SZ_MAIL = 2'h3;

    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_CTRL   = 4'h4;
    localparam int ST_FILL_LSB = 8;
    localparam int ST_THR_LSB  = 16;

    typedef struct packed {
        logic port_a_select_n;
        logic port_a_dir;
        logic port_a_go;
        logic port_a_mail_sel;
    } dcfmb_porta_ctl_s;

    typedef struct packed {
        logic port_b_select_n;
        logic port_b_dir;
        logic port_b_go;
        logic width_sel1;
        logic width_sel0;
        logic big_endian_sel_n;
    } dcfmb_portb_ctl_s;

    typedef struct packed {
        dcfmb_ptr_t  wr_ptr;
        dcfmb_ptr_t  rd_ptr;
        logic [3:0]  wr_age;
        logic [3:0]  rd_age;
        dcfmb_ptr_t  b_wr_v1;
        dcfmb_ptr_t  b_wr_v2;
        dcfmb_ptr_t  a_rd_v1;
        dcfmb_ptr_t  a_rd_v2;
        logic        emp_s1;
        logic        emp;
        logic        nemp_s1;
        logic        nemp;
        logic        ful_s1;
        logic        ful;
        logic        nful_s1;
        logic        nful;
        logic        mb1_n;
        logic        mb2_n;
        dcfmb_word_t mail_ab;
        dcfmb_word_t mail_ba;
        logic [4:0]  thr;
        logic        thr_loaded;
        logic [1:0]  sz_q;
        logic        be_q;
        dcfmb_word_t hold;
        logic [1:0]  held_size;
        logic        held_be;
        logic [1:0]  part_idx;
        logic [1:0]  parts_left;
        dcfmb_word_t out_reg;
        logic        a_clk_q;
        logic        b_clk_q;
        logic        ack;
        logic [31:0] rdata;
    } dcfmb_state_s;
endpackage

// file: verification/dcfmb_port_model.sv
`timescale 1ns/1ps
module dcfmb_port_model #(
    parameter int            CW  = 4,
    parameter logic [CW-1:0] REL = '0
) (
    // System clock
    input  wire logic                   mclk,
    // Port pins
    output      logic                   port_clock,
    output      logic [CW-1:0]          ctl,
    output      dcfmb_pkg::dcfmb_word_t data
);
    import dcfmb_pkg::*;
    initial begin
        port_clock = 1'b0;
        ctl = REL;
        data = '0;
    end
    // Clock stands still between requests, so each edge carries one request
    task automatic xfer(input logic [CW-1:0] c, input dcfmb_word_t d);
        ctl <= c;
        data <= d;
        repeat (2) @(posedge mclk);
        port_clock <= 1'b1;
        @(posedge mclk);
        // Deselect only; size lanes stay so the output mux does not move
        ctl <= c | REL;
        // Released bus shows the inverse rather than a stale copy
        data <= ~d;
        repeat (2) @(posedge mclk);
        port_clock <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask
endmodule // dcfmb_port_model

// file: verification/testbench.sv
`timescale 1ns/1ps
module testbench;
    import dcfmb_pkg::*;
    localparam logic [5:0] RD = 6'h08;
    logic             mclk = 1'b0, rst_n = 1'b0, threshold_sel1 = 1'b0, threshold_sel0 = 1'b0;
    logic             port_a_clock, port_b_clock, a_data_oe, b_data_oe, avs_waitrequest;
    logic             queue_full_n, near_full_n, b_to_a_mail_flag_n, be;
    logic             queue_empty_n, near_empty_n, a_to_b_mail_flag_n;
    dcfmb_porta_ctl_s port_a_ctl;
    dcfmb_portb_ctl_s port_b_ctl;
    dcfmb_word_t      a_data_in, a_data_out, b_data_in, b_data_out, w, prev;
    logic [3:0]       avs_address = 4'h0;
    logic             avs_read = 1'b0, avs_write = 1'b0;
    logic [31:0]      avs_writedata = 32'h0, avs_readdata, rd;
    logic [4:0]       thr;
    logic [1:0]       sz;
    int               fail_count = 0, check_count = 0, n;
    dcfmb_word_t      q[$];
    always #20 mclk = ~mclk;
    dcfmb_port_model #(.CW(4), .REL(4'h8)) u_pa (.mclk, .port_clock(port_a_clock),
        .ctl(port_a_ctl), .data(a_data_in));
    dcfmb_port_model #(.CW(6), .REL(6'h20)) u_pb (.mclk, .port_clock(port_b_clock),
        .ctl(port_b_ctl), .data(b_data_in));
    dcfmb_top u_dut (.mclk, .rst_n, .threshold_sel1, .threshold_sel0, .port_a_clock,
        .port_a_ctl, .a_data_in, .a_data_out, .a_data_oe, .queue_full_n, .near_full_n,
        .b_to_a_mail_flag_n, .port_b_clock, .port_b_ctl, .b_data_in, .b_data_out, .b_data_oe,
        .queue_empty_n, .near_empty_n, .a_to_b_mail_flag_n, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest);
    task automatic chk(input string what, input dcfmb_word_t exp, input dcfmb_word_t got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Request held until waitrequest is sampled low; data taken at that edge
    task automatic avs(input logic wr, input logic [3:0] adr, output logic [31:0] d);
        avs_address <= adr;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= 32'hffffffff;
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0)
            @(posedge mclk);
        d = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge mclk);
    endtask
    function automatic dcfmb_word_t rnd();
        return {4'($urandom), $urandom};
    endfunction
    // Expected output register after part p of word w; untouched lanes keep o
    function automatic dcfmb_word_t narrow(dcfmb_word_t o, dcfmb_word_t w, logic [1:0] s,
                                           logic be_n, int p);
        int wd;
        wd = (s == SZ_WORD) ? HALF_W : BYTE_W;
        for (int b = 0; b < wd; b++) begin
            if (be_n)
                o[b] = w[p * wd + b];
            else
                o[DATA_W - wd + b] = w[DATA_W - (p + 1) * wd + b];
        end
        return o;
    endfunction
    initial begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        $display("watchdog expired");
        results();
    end
    initial begin
        n = $urandom(32'hbd1a);
        {threshold_sel1, threshold_sel0} <= 2'($urandom);
        repeat (3) @(posedge mclk);
        chk("reset flags", 36'h07, {queue_full_n, queue_empty_n, near_empty_n, near_full_n,
            a_to_b_mail_flag_n, b_to_a_mail_flag_n});
        rst_n <= 1'b1;
        thr = 5'h04 * ({threshold_sel1, threshold_sel0} + 5'h01);
        repeat (2) u_pa.xfer(4'h8, '0);
        chk("full_n", 1, queue_full_n);
        avs(1'b0, REG_STATUS, rd);
        chk("threshold", thr, rd[20:16]);
        avs(1'b1, REG_STATUS, rd);
        avs(1'b0, 4'hc, rd);
        chk("unmapped", 0, rd);
        $display("test reset done");
        for (int i = 0; i < DEPTH; i++) begin
            w = rnd();
            u_pa.xfer(4'h6, w);
            q.push_back(w);
            chk("near_full_n", q.size() < DEPTH - thr, near_full_n);
            if (i == 0) begin
                u_pb.xfer(6'h20, '0);
                chk("empty_n early", 0, queue_empty_n);
                u_pb.xfer(6'h20, '0);
                chk("empty_n", 1, queue_empty_n);
            end
        end
        chk("full_n", 0, queue_full_n);
        u_pa.xfer(4'h6, ~q[0]);
        repeat (2) u_pb.xfer(6'h20, '0);
        chk("near_empty_n", 1, near_empty_n);
        $display("test fill done");
        u_pb.xfer(RD, '0);
        chk("long read", q.pop_front(), b_data_out);
        u_pa.xfer(4'h8, '0);
        chk("full_n held", 0, queue_full_n);
        u_pa.xfer(4'h8, '0);
        chk("full_n freed", 1, queue_full_n);
        for (int m = 0; m < 4; m++) begin
            sz = m[1] ? SZ_BYTE : SZ_WORD;
            be = m[0];
            u_pb.xfer({3'h0, sz, be}, '0);
            w = q.pop_front();
            for (int p = 0; p < (m[1] ? 4 : 2); p++) begin
                prev = b_data_out;
                u_pb.xfer(RD | {3'h0, sz, be}, '0);
                chk("narrow", narrow(prev, w, sz, be, p), b_data_out);
            end
        end
        u_pb.xfer({3'h0, SZ_WORD, 1'b1}, '0);
        u_pb.xfer(RD | {3'h0, SZ_WORD, 1'b1}, '0);
        void'(q.pop_front());
        u_pb.xfer(6'h00, '0);
        u_pb.xfer(RD, '0);
        chk("fresh word", q.pop_front(), b_data_out);
        $display("test sizing done");
        w = rnd();
        u_pa.xfer(4'h7, w);
        chk("a_to_b flag low", 0, a_to_b_mail_flag_n);
        u_pa.xfer(4'h7, ~w);
        u_pb.xfer(6'h0f, '0);
        chk("a_to_b mail", w, b_data_out);
        chk("a_to_b flag high", 1, a_to_b_mail_flag_n);
        w = rnd();
        u_pb.xfer(6'h1f, w);
        chk("b_to_a flag low", 0, b_to_a_mail_flag_n);
        u_pa.xfer(4'h3, '0);
        chk("b_to_a mail", w, a_data_out);
        chk("b_to_a flag high", 1, b_to_a_mail_flag_n);
        chk("a_data_oe", 0, a_data_oe);
        $display("test mailbox done");
        while (q.size() > 0) begin
            u_pb.xfer(RD, '0);
            chk("drain", q.pop_front(), b_data_out);
            chk("near_empty_n", q.size() > thr, near_empty_n);
        end
        repeat (2) u_pa.xfer(4'h8, '0);
        chk("near_full_n", 1, near_full_n);
        chk("empty_n", 0, queue_empty_n);
        prev = b_data_out;
        u_pb.xfer(RD, '0);
        chk("read when empty", prev, b_data_out);
        chk("b_data_oe", 0, b_data_oe);
        avs(1'b1, REG_CTRL, rd);
        avs(1'b0, REG_CTRL, rd);
        chk("ctrl", 36'h1f, rd);
        $display("test drain done");
        results();
    end
endmodule // testbench
